// ==== include/gw_regs.svh ====
`ifndef GW_REGS_SVH
`define GW_REGS_SVH
`define OP_FAULT_LIST 8'h60
`define OP_AUTO_ADDR  8'he1
`define OP_MOTOR_CFG  8'he2
`define REC_READ      8'h01
`define REC_WRITE     8'h02
`define REC_SUBSLOT   8'h01
`define SLOT_SEG1     8'h00
`define SLOT_SEG2     8'h64
`define MOTOR_MAX     8'h10
`define ERR_OK        7'h00
`define ERR_UNKNOWN   7'h01
`define ERR_ABSENT    7'h21
`define ERR_NO_MOTOR  7'h22
`define ERR_CFG_LEN   7'h23
`define STAT_OK       4'h0
`define STAT_FAIL     4'hf
`define LEN_SHORT     6'h02
`define LEN_LIST      6'h0a
`define LEN_AUTO      6'h03
`define LEN_REC_READ  6'h24
`define LEN_REC_WRITE 6'h01
`define LEN_REC_WREQ  6'h23
`define LEN_REC_RREQ  6'h03
`define IMG_FIRST     6'h02
`define IMG_LAST      6'h21
`define REC_STAT_BYTE 6'h23
`define REC_DATA_OFS  6'h03
`define CFG_DATA_OFS  6'h04
`define BIT_TOGGLE    7
`define BIT_AB        5
`endif

// ==== include/gw_pkg.sv ====
package gw_pkg;
  typedef enum logic [1:0] {D_RECV, D_EXEC, D_SEND} dev_state_t;
  typedef enum logic [1:0] {H_IDLE, H_SEND, H_RECV} host_state_t;
  typedef logic [31:0][7:0] frame_data_t;
endpackage

// ==== include/gw_link_if.sv ====
`timescale 1ns/1ps
interface gw_link_if;
  logic       req_valid;
  logic [7:0] req_data;
  logic       req_last;
  logic       req_ready;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       rsp_last;
  logic       rsp_ready;
  modport dev (input req_valid, req_data, req_last, rsp_ready,
               output req_ready, rsp_valid, rsp_data, rsp_last);
  modport host (output req_valid, req_data, req_last, rsp_ready,
                input req_ready, rsp_valid, rsp_data, rsp_last);
endinterface

// ==== core/node_fault_list.sv ====
`timescale 1ns/1ps
module node_fault_list #(
  parameter int NODES = 64
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [NODES-1:0] node_active,
  input  wire logic             clear,
  output logic      [NODES-1:0] list
);
  typedef struct packed {
    logic [NODES-1:0] prev;
    logic [NODES-1:0] list;
  } trk_t;
  trk_t q;
  trk_t d;

  always_comb begin
    d = q;
    d.prev = node_active;
    // Set wins over clear so a drop during the read is kept
    d.list = (q.list & ~{NODES{clear}}) | (q.prev & ~node_active);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign list = q.list;
endmodule

// ==== core/gw_device.sv ====
// Contract
// - Code 0x60 returns sticky node fault bitmap
// - Fault list request has no payload
// - Fault list payload is eight bytes
// - Bit set when enabled node drops out
// - Bits stay until list read, then clear
// - Positions without node address carry nothing
// - Code 0xE1 reports auto addressing state
// - Auto addressing payload one byte, bit 0
// - Flag one when on, zero when off
// - Code 0xE2 replaces node motor configuration
// - Only active motor capable nodes are written
// - Host sends length byte, at most 16
// - Error zero ok, 0x21 node absent
// - Record index 1 subslot 1 reads inputs
// - Slot 0 segment one, 100 segment two
// - Input image nibble per node, status byte 35
// - Record index 2 writes output image
`timescale 1ns/1ps
`include "gw_regs.svh"
module gw_device #(
  parameter int SEGS  = 2,
  parameter int NODES = 64
) (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  gw_link_if.dev                      link,
  input  wire logic [SEGS*NODES-1:0]  node_active,
  input  wire logic [SEGS*NODES-1:0]  node_motor,
  input  wire logic [SEGS-1:0]        auto_addr,
  input  wire logic [SEGS*NODES*4-1:0] in_image,
  output logic      [SEGS*NODES*4-1:0] out_image,
  output logic                        motor_wr,
  output logic                        motor_seg,
  output logic      [5:0]             motor_node,
  output logic      [4:0]             motor_len,
  output logic      [127:0]           motor_cfg
);
  localparam int IMG = NODES * 4;

  typedef struct packed {
    gw_pkg::dev_state_t  st;
    logic [5:0]          idx;
    logic [7:0]          op;
    logic [7:0]          b1;
    logic [7:0]          b2;
    logic [7:0]          b3;
    gw_pkg::frame_data_t dat;
    logic [5:0]          len;
    logic [6:0]          err;
    logic [3:0]          status;
    logic [SEGS-1:0][IMG-1:0] oimg;
    logic                mwr;
    logic                mseg;
    logic [5:0]          mnode;
    logic [4:0]          mlen;
    logic                req_ready;
    logic                rsp_valid;
    logic                rsp_last;
    logic [7:0]          rsp_data;
  } core_t;

  core_t q;
  core_t d;
  logic [SEGS-1:0]            list_clr;
  logic [SEGS-1:0][NODES-1:0] fault;

  genvar g;
  generate
    for (g = 0; g < SEGS; g++) begin : g_seg
      node_fault_list #(.NODES(NODES)) u_list (
        .clk         (clk),
        .nrst        (nrst),
        .node_active (node_active[g*NODES +: NODES]),
        .clear       (list_clr[g]),
        .list        (fault[g])
      );
      assign out_image[g*IMG +: IMG] = q.oimg[g];
    end
  endgenerate

  function automatic logic is_rec(input logic [7:0] op);
    return (op == `REC_READ) || (op == `REC_WRITE);
  endfunction

  function automatic logic [7:0] resp_byte(input core_t s, input logic [5:0] i);
    logic [5:0] k;
    k = i - `IMG_FIRST;
    if (s.op == `REC_WRITE) begin
      return {4'h0, s.status};
    end else if (s.op == `REC_READ) begin
      if (i == `REC_STAT_BYTE) begin
        return {4'h0, s.status};
      end else if (i >= `IMG_FIRST && i <= `IMG_LAST) begin
        return s.dat[k[4:0]];
      end else begin
        return 8'h00;
      end
    end else if (i == 6'h00) begin
      return s.op;
    end else if (i == 6'h01) begin
      return {s.b1[`BIT_TOGGLE], s.err};
    end else begin
      return s.dat[k[4:0]];
    end
  endfunction

  logic        seg;
  logic        rseg;
  logic        rec_ok;
  logic [6:0]  node;
  logic [5:0]  dofs;
  logic [5:0]  nidx;
  logic [NODES-1:0] flist;

  always_comb begin
    d = q;
    d.mwr = 1'b0;
    list_clr = '0;
    seg = q.b1[0];
    rseg = (q.b1 == `SLOT_SEG2);
    rec_ok = ((q.b1 == `SLOT_SEG1) || rseg) && (q.b2 == `REC_SUBSLOT);
    node = {seg, q.b2[`BIT_AB], q.b2[4:0]};
    dofs = (q.op == `REC_WRITE) ? `REC_DATA_OFS : `CFG_DATA_OFS;
    nidx = q.idx - dofs;
    flist = fault[seg];
    flist[0] = 1'b0;
    flist[NODES/2] = 1'b0;
    unique case (q.st)
      gw_pkg::D_RECV: begin
        if (link.req_valid) begin
          // Header bytes only; an early last just leaves them stale
          unique case (q.idx)
            6'h00: d.op = link.req_data;
            6'h01: d.b1 = link.req_data;
            6'h02: d.b2 = link.req_data;
            6'h03: d.b3 = link.req_data;
            default: ;
          endcase
          if (q.idx >= dofs && nidx < 6'h20 && (is_rec(q.op) || q.op == `OP_MOTOR_CFG)) begin
            d.dat[nidx[4:0]] = link.req_data;
          end
          if (q.idx != 6'h3f) begin
            d.idx = q.idx + 6'h01;
          end
          if (link.req_last) begin
            d.st = gw_pkg::D_EXEC;
            d.req_ready = 1'b0;
          end
        end
      end
      gw_pkg::D_EXEC: begin
        d.err = `ERR_OK;
        d.status = `STAT_OK;
        d.len = `LEN_SHORT;
        unique case (q.op)
          `OP_FAULT_LIST: begin
            // No payload expected; extra bytes were ignored
            d.dat = '0;
            d.dat[7:0] = flist;
            list_clr[seg] = 1'b1;
            d.len = `LEN_LIST;
          end
          `OP_AUTO_ADDR: begin
            d.dat = '0;
            d.dat[0] = {7'h00, auto_addr[seg]};
            d.len = `LEN_AUTO;
          end
          `OP_MOTOR_CFG: begin
            if (q.b3 > `MOTOR_MAX) begin
              d.err = `ERR_CFG_LEN;
            end else if (!node_active[node]) begin
              d.err = `ERR_ABSENT;
            end else if (!node_motor[node]) begin
              d.err = `ERR_NO_MOTOR;
            end else begin
              d.mwr = 1'b1;
              d.mseg = seg;
              d.mnode = node[5:0];
              d.mlen = q.b3[4:0];
            end
          end
          `REC_READ: begin
            d.len = `LEN_REC_READ;
            d.dat = '0;
            if (rec_ok) begin
              for (int j = 0; j < 32; j++) begin
                d.dat[j] = {in_image[rseg*IMG + 8*j +: 4], in_image[rseg*IMG + 8*j + 4 +: 4]};
              end
              d.dat[0][7:4] = 4'h0;
              d.dat[16][7:4] = 4'h0;
            end else begin
              d.status = `STAT_FAIL;
            end
          end
          `REC_WRITE: begin
            d.len = `LEN_REC_WRITE;
            if (rec_ok) begin
              for (int j = 0; j < 32; j++) begin
                d.oimg[rseg][8*j +: 4] = q.dat[j][7:4];
                d.oimg[rseg][8*j + 4 +: 4] = q.dat[j][3:0];
              end
            end else begin
              d.status = `STAT_FAIL;
            end
          end
          default: d.err = `ERR_UNKNOWN;
        endcase
        d.st = gw_pkg::D_SEND;
        d.idx = 6'h00;
        d.rsp_valid = 1'b1;
        d.rsp_data = resp_byte(d, 6'h00);
        d.rsp_last = (d.len == 6'h01);
      end
      gw_pkg::D_SEND: begin
        if (link.rsp_ready) begin
          if (q.rsp_last) begin
            d.st = gw_pkg::D_RECV;
            d.idx = 6'h00;
            d.rsp_valid = 1'b0;
            d.rsp_last = 1'b0;
            d.req_ready = 1'b1;
          end else begin
            d.idx = q.idx + 6'h01;
            d.rsp_data = resp_byte(q, q.idx + 6'h01);
            d.rsp_last = (q.idx + 6'h02 == q.len);
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= '0;
      q.req_ready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign link.req_ready = q.req_ready;
  assign link.rsp_valid = q.rsp_valid;
  assign link.rsp_data  = q.rsp_data;
  assign link.rsp_last  = q.rsp_last;
  assign motor_wr   = q.mwr;
  assign motor_seg  = q.mseg;
  assign motor_node = q.mnode;
  assign motor_len  = q.mlen;
  assign motor_cfg  = q.dat[15:0];
endmodule

// ==== core/gw_host.sv ====
`timescale 1ns/1ps
`include "gw_regs.svh"
module gw_host (
  input  wire logic         clk,
  input  wire logic         nrst,
  gw_link_if.host           link,
  input  wire logic         start,
  input  wire logic [7:0]   op,
  input  wire logic         seg,
  input  wire logic [5:0]   node,
  input  wire logic [7:0]   cfg_len,
  input  wire logic [255:0] payload,
  output logic              busy,
  output logic              done,
  output logic [6:0]        err,
  output logic              toggle_ok,
  output logic [3:0]        status,
  output logic [255:0]      rsp_payload
);
  typedef struct packed {
    gw_pkg::host_state_t st;
    logic [5:0]          idx;
    logic [5:0]          len;
    logic [7:0]          op;
    logic                seg;
    logic [5:0]          node;
    logic [4:0]          clen;
    logic                tog;
    gw_pkg::frame_data_t pay;
    gw_pkg::frame_data_t rdat;
    logic [6:0]          err;
    logic                tok;
    logic [3:0]          status;
    logic                done;
    logic                req_valid;
    logic                req_last;
    logic [7:0]          req_data;
  } host_core_t;

  host_core_t q;
  host_core_t d;

  function automatic logic [7:0] req_byte(input host_core_t s, input logic [5:0] i);
    logic [5:0] k;
    k = i - ((s.op == `REC_WRITE) ? `REC_DATA_OFS : `CFG_DATA_OFS);
    if (i == 6'h00) begin
      return s.op;
    end else if (s.op == `REC_READ || s.op == `REC_WRITE) begin
      if (i == 6'h01) begin
        return s.seg ? `SLOT_SEG2 : `SLOT_SEG1;
      end else if (i == 6'h02) begin
        return `REC_SUBSLOT;
      end else begin
        return s.pay[k[4:0]];
      end
    end else if (i == 6'h01) begin
      return {s.tog, 6'h00, s.seg};
    end else if (i == 6'h02) begin
      return {2'b00, s.node};
    end else if (i == 6'h03) begin
      return {3'b000, s.clen};
    end else begin
      return s.pay[k[4:0]];
    end
  endfunction

  logic [5:0] k;

  always_comb begin
    d = q;
    d.done = 1'b0;
    k = q.idx - `IMG_FIRST;
    unique case (q.st)
      gw_pkg::H_IDLE: begin
        if (start) begin
          d.op = op;
          d.seg = seg;
          d.node = node;
          // Over-long configurations are cut to the legal maximum
          d.clen = (cfg_len > `MOTOR_MAX) ? 5'h10 : cfg_len[4:0];
          d.pay = payload;
          d.tog = (op == `REC_READ || op == `REC_WRITE) ? q.tog : ~q.tog;
          unique case (op)
            `REC_READ: d.len = `LEN_REC_RREQ;
            `REC_WRITE: d.len = `LEN_REC_WREQ;
            `OP_MOTOR_CFG: d.len = `CFG_DATA_OFS + {1'b0, d.clen};
            default: d.len = `LEN_SHORT;
          endcase
          d.idx = 6'h00;
          d.rdat = '0;
          d.st = gw_pkg::H_SEND;
          d.req_valid = 1'b1;
          d.req_data = req_byte(d, 6'h00);
          d.req_last = (d.len == 6'h01);
        end
      end
      gw_pkg::H_SEND: begin
        if (link.req_ready) begin
          if (q.req_last) begin
            d.st = gw_pkg::H_RECV;
            d.idx = 6'h00;
            d.req_valid = 1'b0;
            d.req_last = 1'b0;
          end else begin
            d.idx = q.idx + 6'h01;
            d.req_data = req_byte(q, q.idx + 6'h01);
            d.req_last = (q.idx + 6'h02 == q.len);
          end
        end
      end
      gw_pkg::H_RECV: begin
        if (link.rsp_valid) begin
          if (q.op == `REC_WRITE || (q.op == `REC_READ && q.idx == `REC_STAT_BYTE)) begin
            d.status = link.rsp_data[3:0];
          end else if (q.op != `REC_READ && q.idx == 6'h01) begin
            d.err = link.rsp_data[6:0];
            d.tok = (link.rsp_data[`BIT_TOGGLE] == q.tog);
          end else if (q.idx >= `IMG_FIRST && q.idx <= `IMG_LAST) begin
            d.rdat[k[4:0]] = link.rsp_data;
          end
          d.idx = q.idx + 6'h01;
          if (link.rsp_last) begin
            d.st = gw_pkg::H_IDLE;
            d.done = 1'b1;
          end
        end
      end
      default: d.st = gw_pkg::H_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign link.req_valid = q.req_valid;
  assign link.req_data  = q.req_data;
  assign link.req_last  = q.req_last;
  assign link.rsp_ready = (q.st == gw_pkg::H_RECV);
  assign busy        = (q.st != gw_pkg::H_IDLE);
  assign done        = q.done;
  assign err         = q.err;
  assign toggle_ok   = q.tok;
  assign status      = q.status;
  assign rsp_payload = q.rdat;
endmodule

// ==== bench/gw_link_checker.sv ====
`timescale 1ns/1ps
`include "gw_regs.svh"
module gw_link_checker (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       req_valid,
  input wire logic [7:0] req_data,
  input wire logic       req_last,
  input wire logic       req_ready,
  input wire logic       rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic       rsp_last,
  input wire logic       rsp_ready
);
  logic [5:0] qcnt_q;
  logic [5:0] rcnt_q;
  logic [7:0] code_q;
  logic       tog_q;
  logic       mbox;
  logic [5:0] rsp_len;
  assign mbox = code_q != `REC_READ && code_q != `REC_WRITE;
  always_comb begin
    case (code_q)
      `OP_FAULT_LIST: rsp_len = `LEN_LIST;
      `OP_AUTO_ADDR:  rsp_len = `LEN_AUTO;
      `REC_READ:      rsp_len = `LEN_REC_READ;
      `REC_WRITE:     rsp_len = `LEN_REC_WRITE;
      default:        rsp_len = `LEN_SHORT;
    endcase
  end
  // Remembers code and toggle of the frame being answered
  always_ff @(posedge clk) begin
    if (!nrst) begin
      qcnt_q <= 6'h00;
      rcnt_q <= 6'h00;
      code_q <= 8'h00;
      tog_q  <= 1'b0;
    end else begin
      if (req_valid && req_ready) begin
        qcnt_q <= req_last ? 6'h00 : qcnt_q + 6'h01;
        if (qcnt_q == 6'h00) code_q <= req_data;
        if (qcnt_q == 6'h01) tog_q <= req_data[7];
      end
      if (rsp_valid && rsp_ready) rcnt_q <= rsp_last ? 6'h00 : rcnt_q + 6'h01;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence last_in;
    req_valid && req_ready && req_last;
  endsequence
  sequence last_out;
    rsp_valid && rsp_ready && rsp_last;
  endsequence
  stall_after_frame_a: assert property (last_in |=> !req_ready)
    else $error("request accepted after last byte");
  answer_delay_a: assert property (last_in |=> !rsp_valid ##1 rsp_valid)
    else $error("response not two cycles after frame");
  code_echo_a: assert property ($rose(rsp_valid) |-> rsp_data == (mbox ? code_q : 8'h00))
    else $error("first response byte wrong");
  toggle_echo_a: assert property ($rose(rsp_valid) && rsp_ready && mbox |=> rsp_data[7] == tog_q)
    else $error("toggle not echoed");
  resp_length_a: assert property (last_out |-> rcnt_q + 6'h01 == rsp_len)
    else $error("response length wrong");
  link_release_a: assert property (last_out |=> req_ready && !rsp_valid)
    else $error("link not released after response");
  no_overlap_a: assert property (req_ready |-> !rsp_valid)
    else $error("response while collecting request");
  auto_pad_a: assert property (rsp_valid && code_q == `OP_AUTO_ADDR && rcnt_q == 6'h02 |-> rsp_data[7:1] == 7'h00)
    else $error("auto flag byte upper bits set");
  rec_pad_a: assert property (rsp_valid && code_q == `REC_READ && rcnt_q == 6'h22 |-> rsp_data == 8'h00)
    else $error("record byte 34 not zero");
endmodule

// ==== bench/field_gateway_command_handler_test.sv ====
`timescale 1ns/1ps
module field_gateway_command_handler_test;
  logic         clk;
  logic         nrst;
  logic         start;
  logic [7:0]   op;
  logic         seg;
  logic [5:0]   node;
  logic [7:0]   cfg_len;
  logic [255:0] payload;
  logic         busy;
  logic         done;
  logic [6:0]   err;
  logic         toggle_ok;
  logic [3:0]   status;
  logic [255:0] rsp_payload;
  logic [127:0] node_active;
  logic [127:0] node_motor;
  logic [1:0]   auto_addr;
  logic [511:0] in_image;
  logic [511:0] out_image;
  logic         motor_wr;
  logic         motor_seg;
  logic [5:0]   motor_node;
  logic [4:0]   motor_len;
  logic [127:0] motor_cfg;
  logic [139:0] wr_rec;
  logic [255:0] nib;
  int           n_wr = 0;
  int           n_mismatch = 0;
  int           checked = 0;
  gw_link_if link ();
  gw_host gw_host_i (.clk(clk), .nrst(nrst), .link(link.host), .start(start), .op(op), .seg(seg),
    .node(node), .cfg_len(cfg_len), .payload(payload), .busy(busy), .done(done), .err(err),
    .toggle_ok(toggle_ok), .status(status), .rsp_payload(rsp_payload));
  gw_device gw_device_i (.clk(clk), .nrst(nrst), .link(link.dev), .node_active(node_active),
    .node_motor(node_motor), .auto_addr(auto_addr), .in_image(in_image), .out_image(out_image),
    .motor_wr(motor_wr), .motor_seg(motor_seg), .motor_node(motor_node), .motor_len(motor_len),
    .motor_cfg(motor_cfg));
  gw_link_checker gw_link_checker_i (.clk(clk), .nrst(nrst), .req_valid(link.req_valid),
    .req_data(link.req_data), .req_last(link.req_last), .req_ready(link.req_ready),
    .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data), .rsp_last(link.rsp_last),
    .rsp_ready(link.rsp_ready));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Pulse is one cycle wide, so capture it here
  always @(posedge clk) begin
    if (motor_wr === 1'b1) begin
      n_wr <= n_wr + 1;
      wr_rec <= {motor_seg, motor_node, motor_len, motor_cfg};
    end
  end

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [255:0] exp, input logic [255:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic cmd(input logic [7:0] c, input logic s, input logic [5:0] nd, input logic [7:0] len,
                     input logic [255:0] pl);
    int i;
    @(posedge clk);
    start <= 1'b1;
    op <= c;
    seg <= s;
    node <= nd;
    cfg_len <= len;
    payload <= pl;
    @(posedge clk);
    start <= 1'b0;
    i = 0;
    do begin
      @(posedge clk);
      #1;
      i++;
    end while (done !== 1'b1 && i < 400);
    if (done !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED done expected 1 seen %b", done);
      finish_test();
    end else begin
      chk("busy after done", 256'h0, busy);
      if (c != 8'h01 && c != 8'h02) chk("toggle", 256'h1, toggle_ok);
    end
  endtask

  // Image byte j holds even node high, odd node low; node 0 of each range reads 0
  function automatic logic [255:0] pack(input logic [255:0] n);
    logic [255:0] b;
    b = '0;
    for (int j = 0; j < 32; j++) begin
      b[8*j+4 +: 4] = (j % 16 == 0) ? 4'h0 : n[8*j +: 4];
      b[8*j +: 4] = n[8*j+4 +: 4];
    end
    return b;
  endfunction

  initial begin
    nrst = 1'b0;
    start = 1'b0;
    op = 8'h00;
    seg = 1'b0;
    node = 6'h00;
    cfg_len = 8'h00;
    payload = '0;
    node_active = '1;
    node_motor = '0;
    auto_addr = 2'b00;
    in_image = '0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk("out image reset", 256'h0, out_image[255:0]);
    @(posedge clk);
    node_active[0] <= 1'b0;
    node_active[5] <= 1'b0;
    node_active[35] <= 1'b0;
    node_active[97] <= 1'b0;
    @(posedge clk);
    node_active[5] <= 1'b1;
    cmd(8'h60, 1'b0, 6'h00, 8'h00, '0);
    chk("fault list seg1", 64'h0000_0008_0000_0020, rsp_payload[63:0]);
    chk("fault err", 7'h00, err);
    cmd(8'h60, 1'b1, 6'h00, 8'h00, '0);
    chk("fault list seg2", 64'h0000_0002_0000_0000, rsp_payload[63:0]);
    cmd(8'h60, 1'b0, 6'h00, 8'h00, '0);
    chk("fault list cleared", 64'h0, rsp_payload[63:0]);
    auto_addr <= 2'b10;
    for (int k = 0; k < 2; k++) begin
      cmd(8'he1, k[0], 6'h00, 8'h00, '0);
      chk("auto flag", {7'h00, k[0]}, rsp_payload[7:0]);
    end
    node_motor[101] <= 1'b1;
    cmd(8'he2, 1'b1, 6'h25, 8'h10, 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0);
    chk("motor err", 7'h00, err);
    chk("motor record", {1'b1, 6'h25, 5'h10, 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0}, wr_rec);
    chk("motor count", 1, n_wr);
    node_active[7] <= 1'b0;
    cmd(8'he2, 1'b0, 6'h07, 8'h04, 32'h11223344);
    chk("absent err", 7'h21, err);
    cmd(8'he2, 1'b0, 6'h09, 8'h04, 32'h11223344);
    chk("no motor err", 7'h22, err);
    chk("motor refused", 1, n_wr);
    in_image <= {{8{32'h7654_3210}}, {8{32'hfedc_ba98}}};
    for (int k = 0; k < 2; k++) begin
      cmd(8'h01, k[0], 6'h00, 8'h00, '0);
      nib = k[0] ? {8{32'h7654_3210}} : {8{32'hfedc_ba98}};
      chk("input image", pack(nib), rsp_payload);
      chk("read status", 4'h0, status);
    end
    nib = {8{32'h2468_ace1}};
    nib[3:0] = 4'h0;
    nib[131:128] = 4'h0;
    cmd(8'h02, 1'b1, 6'h00, 8'h00, pack(nib));
    chk("output image seg2", nib, out_image[511:256]);
    chk("output image seg1", 256'h0, out_image[255:0]);
    chk("write status", 4'h0, status);
    cmd(8'h33, 1'b0, 6'h00, 8'h00, '0);
    chk("unknown err", 7'h01, err);
    finish_test();
  end
endmodule
